// ==== ssil_pkg.sv ====
package ssil_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] SSIL_ADDR_ENABLE = 32'h4004_0014;
    localparam logic [31:0] SSIL_ADDR_RAW = 32'h4004_0018;
    localparam logic [31:0] SSIL_ADDR_ENABLED = 32'h4004_001C;
    localparam logic [31:0] SSIL_ADDR_CLEAR = 32'h4004_0020;

    ////////////////////////////////////////////////////////////////////////
    // Field layout and reset values
    localparam int unsigned SSIL_COND_W = 4;
    localparam logic [3:0] SSIL_ENABLE_RESET = 4'h0;
    localparam logic [31:0] SSIL_READ_ZERO = 32'h0000_0000;
    localparam int unsigned SSIL_CLR_OVERRUN_BIT = 0;
    localparam int unsigned SSIL_CLR_TIMEOUT_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Bus encodings
    localparam logic [2:0] SSIL_HSIZE_WORD = 3'h2;
    localparam int unsigned SSIL_HTRANS_ACTIVE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Sizes and timing
    localparam int unsigned SSIL_FIFO_DEPTH = 8;
    localparam int unsigned SSIL_TIMEOUT_BITS = 32;
    localparam logic [7:0] SSIL_DIV_MIN = 8'h02;

    // Interrupt conditions, overrun in bit 0
    typedef struct packed {
        logic tx_level;
        logic rx_level;
        logic rx_timeout;
        logic overrun;
    } ssil_cond_t;

    // Register write request in the data phase
    typedef struct packed {
        logic wr_en;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ssil_req_t;

endpackage

// ==== ssil_timeout_timer.sv ====
// Counts bit times while the receive FIFO holds unread data
module ssil_timeout_timer import ssil_pkg::*; #(
    parameter int unsigned BITS = SSIL_TIMEOUT_BITS
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic restart_in,
    input wire logic [7:0] div_in,
    input wire logic [7:0] scr_in,
    output logic expire_out
);
    localparam int unsigned BW = $clog2(BITS + 1);

    generate
        if (BITS < 1) begin : g_bad
            $error("timeout bit count must be at least one");
        end
    endgenerate

    logic [15:0] cyc_reg; // Clocks within current bit
    logic [15:0] cyc_next;
    logic [BW-1:0] bit_reg; // Whole bit times elapsed
    logic [BW-1:0] bit_next;
    logic [7:0] div_even; // Divisor with bit 0 forced low
    logic [15:0] period; // Clocks per serial bit
    logic tick; // One-cycle bit-rate enable

    ////////////////////////////////////////////////////////////////////////
    // Bit-rate divider and bit counter
    always_comb begin
        div_even = {div_in[7:1], 1'b0};
        if (div_even < SSIL_DIV_MIN) begin
            div_even = SSIL_DIV_MIN;
        end
        period = 16'(div_even) * (16'(scr_in) + 16'h0001);
        tick = run_in && !restart_in && (bit_reg != BW'(BITS))
            && (cyc_reg == period - 16'h0001);
        expire_out = tick && (bit_reg == BW'(BITS - 1));
        cyc_next = cyc_reg;
        bit_next = bit_reg;
        if (!run_in || restart_in) begin
            // Empty or just read: start over
            cyc_next = 16'h0000;
            bit_next = '0;
        end else if (tick) begin
            cyc_next = 16'h0000;
            bit_next = bit_reg + BW'(1);
        end else if (bit_reg != BW'(BITS)) begin
            cyc_next = cyc_reg + 16'h0001;
        end
    end

    // Register the counters
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cyc_reg <= 16'h0000;
            bit_reg <= '0;
        end else begin
            cyc_reg <= cyc_next;
            bit_reg <= bit_next;
        end
    end

    AST_EXPIRE_AT_LAST_BIT: assert property (@(posedge clock_in)
        disable iff (!rst_n_in)
        expire_out |-> run_in && cyc_reg == period - 16'h0001
            && bit_reg == BW'(BITS - 1))
        else $error("timeout fired before full period");

endmodule

// ==== ssil_ahb_slave.sv ====
// AHB-Lite slave front end, zero wait states, always OKAY
module ssil_ahb_slave import ssil_pkg::*; (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] rd_data_in,
    output logic [31:0] rd_addr_out,
    output ssil_req_t req_out,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);
    logic wr_reg; // Write data phase pending
    logic wr_next;
    logic [31:0] addr_reg; // Address held for data phase
    logic [31:0] addr_next;
    logic [31:0] rdata_reg; // Read data for data phase
    logic [31:0] rdata_next;
    logic take; // Valid word transfer in address phase

    ////////////////////////////////////////////////////////////////////////
    // Address phase capture
    always_comb begin
        take = hsel_in && hready_in && htrans_in[SSIL_HTRANS_ACTIVE_BIT]
            && (hsize_in == SSIL_HSIZE_WORD);
        wr_next = take && hwrite_in;
        addr_next = take ? haddr_in : addr_reg;
        rdata_next = (take && !hwrite_in) ? rd_data_in : SSIL_READ_ZERO;
    end

    // Register the phase state
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_reg <= 1'b0;
            addr_reg <= 32'h0000_0000;
            rdata_reg <= SSIL_READ_ZERO;
        end else begin
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs
    assign rd_addr_out = haddr_in;
    assign req_out = '{wr_en: wr_reg, addr: addr_reg, wdata: hwdata_in};
    assign hrdata_out = rdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

endmodule

// ==== ssil_irq_top.sv ====
////////////////////////////////////////////////////////////////////////////
//
// Local design decision: register access over AHB-Lite.
module ssil_irq_top import ssil_pkg::*; #(
    parameter int unsigned DEPTH = SSIL_FIFO_DEPTH,
    parameter int unsigned LVL_W = $clog2(DEPTH + 1)
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [LVL_W-1:0] rx_count_in,
    input wire logic [LVL_W-1:0] tx_count_in,
    input wire logic frame_done_in,
    input wire logic rx_read_in,
    input wire logic [7:0] prescale_divisor_in,
    input wire logic [7:0] clock_rate_factor_in,
    output logic overwrite_last_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks
    generate
        if (DEPTH < 2 || (DEPTH % 2) != 0) begin : g_bad_depth
            $error("FIFO depth must be even and at least two");
        end
        if (LVL_W < $clog2(DEPTH + 1)) begin : g_bad_width
            $error("level width too narrow for FIFO depth");
        end
    endgenerate

    localparam logic [LVL_W-1:0] HALF = LVL_W'(DEPTH / 2);
    localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);
    localparam logic [LVL_W-1:0] EMPTY = '0;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    ssil_req_t req; // Write request from the bus
    logic [31:0] rd_addr; // Address of a read being taken
    logic [31:0] rd_data; // Read value for that address

    logic [3:0] enable_reg; // Interrupt enable register
    logic [3:0] enable_next;
    logic overrun_reg; // Sticky overrun condition
    logic overrun_next;
    logic timeout_reg; // Sticky receive time-out condition
    logic timeout_next;
    logic after_reset_reg; // Low in first cycle after reset
    logic after_reset_next;

    ssil_cond_t raw; // Raw interrupt status
    ssil_cond_t enabled; // Enabled interrupt status
    logic rx_full; // Receive FIFO full
    logic rx_nonempty; // Receive FIFO holds data
    logic clr_wr; // Write to clear register
    logic clr_overrun; // Clear request for overrun
    logic clr_timeout; // Clear request for time-out
    logic overrun_event; // Frame completed into full FIFO
    logic expire; // Time-out period elapsed

    ////////////////////////////////////////////////////////////////////////
    // Bus front end
    ssil_ahb_slave u_bus (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hsize_in(hsize_in),
        .hwdata_in(hwdata_in),
        .hready_in(hready_in),
        .rd_data_in(rd_data),
        .rd_addr_out(rd_addr),
        .req_out(req),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Receive time-out counter
    ssil_timeout_timer #(
        .BITS(SSIL_TIMEOUT_BITS)
    ) u_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .run_in(rx_nonempty),
        .restart_in(rx_read_in),
        .div_in(prescale_divisor_in),
        .scr_in(clock_rate_factor_in),
        .expire_out(expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // FIFO level decode
    always_comb begin
        rx_full = (rx_count_in >= FULL);
        rx_nonempty = (rx_count_in != EMPTY);
        overrun_event = frame_done_in && rx_full;
        // Tell the receive FIFO to replace its newest entry
        overwrite_last_out = overrun_event;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status assembly
    always_comb begin
        raw.overrun = overrun_reg;
        raw.rx_timeout = timeout_reg;
        // Level conditions come straight from the FIFO counts
        raw.rx_level = (rx_count_in >= HALF);
        raw.tx_level = (tx_count_in <= HALF);
        enabled = raw & ssil_cond_t'(enable_reg);
        irq_out = |enabled;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register write decode
    always_comb begin
        clr_wr = req.wr_en && (req.addr == SSIL_ADDR_CLEAR);
        // Only ones clear; zeros leave conditions alone
        clr_overrun = clr_wr && req.wdata[SSIL_CLR_OVERRUN_BIT];
        clr_timeout = clr_wr && req.wdata[SSIL_CLR_TIMEOUT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of enables and sticky conditions
    always_comb begin
        enable_next = enable_reg;
        if (req.wr_en && (req.addr == SSIL_ADDR_ENABLE)) begin
            // Reserved upper bits are dropped
            enable_next = req.wdata[SSIL_COND_W-1:0];
        end
        // New overrun wins over a clear in the same cycle
        overrun_next = overrun_event || (overrun_reg && !clr_overrun);
        if (!rx_nonempty || rx_read_in) begin
            // Cause gone: FIFO empty or read
            timeout_next = 1'b0;
        end else begin
            // Expiry wins over a simultaneous clear
            timeout_next = expire || (timeout_reg && !clr_timeout);
        end
        after_reset_next = 1'b1;
    end

    // Register the state
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_reg <= SSIL_ENABLE_RESET;
            overrun_reg <= 1'b0;
            timeout_reg <= 1'b0;
            after_reset_reg <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            overrun_reg <= overrun_next;
            timeout_reg <= timeout_next;
            after_reset_reg <= after_reset_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer
    always_comb begin
        case (rd_addr)
            SSIL_ADDR_ENABLE: begin
                rd_data = {28'h000_0000, enable_reg};
            end
            SSIL_ADDR_RAW: begin
                rd_data = {28'h000_0000, raw};
            end
            SSIL_ADDR_ENABLED: begin
                rd_data = {28'h000_0000, enabled};
            end
            default: begin
                // Clear register and unmapped addresses read zero
                rd_data = SSIL_READ_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_OVERRUN_SET: assert property (
        frame_done_in && rx_count_in == FULL |=> raw.overrun)
        else $error("overrun not set on frame into full FIFO");

    AST_OVERWRITE: assert property (
        frame_done_in && rx_count_in == FULL |-> overwrite_last_out)
        else $error("overrun frame did not replace previous data");

    AST_TIMEOUT_EMPTY: assert property (
        rx_count_in == EMPTY |=> !raw.rx_timeout)
        else $error("time-out set with empty receive FIFO");

    AST_RX_LEVEL: assert property (
        raw.rx_level == (2 * int'(rx_count_in) >= int'(DEPTH)))
        else $error("receive level status wrong");

    AST_TX_LEVEL: assert property (
        raw.tx_level
            == (2 * (int'(DEPTH) - int'(tx_count_in)) >= int'(DEPTH)))
        else $error("transmit level status wrong");

    AST_ENABLED_AND: assert property (
        enabled == ssil_cond_t'(enable_reg & {tx_count_in <= HALF,
            rx_count_in >= HALF, timeout_reg, overrun_reg}))
        else $error("enabled status not raw AND enables");

    AST_CLEAR_OVERRUN: assert property (
        overrun_reg && clr_wr && req.wdata[0] && !frame_done_in
        |=> !overrun_reg)
        else $error("overrun not cleared by write of one");

    AST_TIMEOUT_HOLD: assert property (
        timeout_reg && !clr_timeout && !rx_read_in
            && rx_count_in != EMPTY
        |=> timeout_reg [*1] ##0 $stable(timeout_reg))
        else $error("time-out dropped without cause");

    AST_ENABLE_RESET: assert property (
        !after_reset_reg |-> enable_reg == 4'h0)
        else $error("enables not zero after reset");

    AST_IRQ_OR: assert property (
        irq_out == (enabled != 4'h0))
        else $error("interrupt not OR of enabled status");

    AST_CLEAR_ZERO: assert property (
        overrun_reg && clr_wr && !req.wdata[0] |=> overrun_reg)
        else $error("writing zero cleared overrun");

    // Sticky overrun holds until cleared and never sets on its own
    AST_OVERRUN_HOLD: assert property (
        overrun_reg && !clr_overrun |=> overrun_reg)
        else $error("overrun dropped without a clear");

    AST_OVERRUN_QUIET: assert property (
        !overrun_reg && !(frame_done_in && rx_count_in == FULL)
        |=> !overrun_reg)
        else $error("overrun set without a frame into full FIFO");

    // The overwrite request only goes out for a frame into a full FIFO
    AST_OVERWRITE_ONLY_FULL: assert property (
        overwrite_last_out |-> frame_done_in && rx_count_in == FULL)
        else $error("overwrite requested without overrun");

    // Expiry with unread data raises the time-out
    AST_TIMEOUT_SET: assert property (
        expire && rx_count_in != EMPTY && !rx_read_in
        |=> raw.rx_timeout)
        else $error("time-out not raised on expiry");

    // A one in bit 1 drops the time-out unless it expires again
    AST_CLEAR_TIMEOUT: assert property (
        timeout_reg && clr_timeout && !expire |=> !timeout_reg)
        else $error("time-out not cleared by write of one");

    // Reading the FIFO removes the time-out cause
    AST_TIMEOUT_READ: assert property (
        rx_read_in |=> !raw.rx_timeout)
        else $error("time-out survived a FIFO read");

    // A write to the enable register lands in the next cycle
    AST_ENABLE_WRITE: assert property (
        req.wr_en && req.addr == SSIL_ADDR_ENABLE
        |=> enable_reg == $past(req.wdata[SSIL_COND_W-1:0]))
        else $error("enable register write lost");

    // No enable bit set means no interrupt
    AST_IRQ_DISABLED: assert property (
        enable_reg == SSIL_ENABLE_RESET |-> !irq_out)
        else $error("interrupt raised with all enables clear");

endmodule

// ==== ssil_irq_top_tb.sv ====
module ssil_irq_top_tb import ssil_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // Bench signals
    logic clock_in = 1'b0; // 50 MHz clock
    logic rst_n_in = 1'b0; // Reset, active low
    logic hsel_in = 1'b0; // Bus select
    logic [31:0] haddr_in = 32'h0000_0000; // Byte address
    logic [1:0] htrans_in = 2'h0; // Transfer kind
    logic hwrite_in = 1'b0; // Write flag
    logic [2:0] hsize_in = SSIL_HSIZE_WORD; // Word transfers only
    logic [31:0] hwdata_in = 32'h0000_0000; // Write data
    logic [31:0] hrdata_out; // Read data
    logic hreadyout_out; // Slave ready, also bus ready
    logic hresp_out; // Response
    logic [3:0] rx_count_in = 4'h0; // Receive FIFO entries
    logic [3:0] tx_count_in = 4'h0; // Transmit FIFO entries
    logic frame_done_in = 1'b0; // Frame received pulse
    logic rx_read_in = 1'b0; // FIFO read pulse
    logic [7:0] prescale_divisor_in = 8'h02;
    logic [7:0] clock_rate_factor_in = 8'h00; // Rate factor
    logic overwrite_last_out; // Overwrite newest entry
    logic irq_out; // Interrupt line
    logic [31:0] rd; // Last read word
    int fails = 0; // Mismatch count
    int tests_run = 0; // Comparison count
    int cycles = 0; // Cycle count for the hang limit

    // Clock generator
    always #10 clock_in = ~clock_in;

    // Design under test
    ssil_irq_top dut_u (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .rx_count_in(rx_count_in), .tx_count_in(tx_count_in),
        .frame_done_in(frame_done_in), .rx_read_in(rx_read_in),
        .prescale_divisor_in(prescale_divisor_in),
        .clock_rate_factor_in(clock_rate_factor_in),
        .overwrite_last_out(overwrite_last_out), .irq_out(irq_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare one value against its expectation
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Wait for ready at a rising edge; only the hang limit ends a wait
    task automatic wait_ready();
        do begin
            @(posedge clock_in);
        end while (hreadyout_out !== 1'b1);
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic ahb_xfer(input logic wr, input logic [31:0] addr,
                            input logic [31:0] wdata);
        hsel_in <= 1'b1;
        haddr_in <= addr;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        wait_ready();
        htrans_in <= 2'h0;
        hwdata_in <= wdata;
        wait_ready();
        rd = hrdata_out;
        check({31'h0, hresp_out}, 32'h0);
    endtask

    // Read a register and compare it
    task automatic read_chk(input logic [31:0] addr, input logic [31:0] exp);
        ahb_xfer(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask

    // Pass a number of clock cycles
    task automatic idle(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset();
        read_chk(SSIL_ADDR_ENABLE, 32'h0);
        read_chk(SSIL_ADDR_RAW, 32'h8);
        read_chk(SSIL_ADDR_ENABLED, 32'h0);
        read_chk(32'h4004_0030, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        $display("test reset done");
    endtask

    // Level conditions follow the FIFO counts only
    task automatic test_levels();
        rx_count_in <= 4'h4;
        tx_count_in <= 4'h5;
        read_chk(SSIL_ADDR_RAW, 32'h4);
        ahb_xfer(1'b1, SSIL_ADDR_ENABLE, 32'hC);
        read_chk(SSIL_ADDR_ENABLED, 32'h4);
        check({31'h0, irq_out}, 32'h1);
        ahb_xfer(1'b1, SSIL_ADDR_CLEAR, 32'h3);
        read_chk(SSIL_ADDR_RAW, 32'h4);
        rx_count_in <= 4'h3;
        tx_count_in <= 4'h4;
        read_chk(SSIL_ADDR_RAW, 32'h8);
        read_chk(SSIL_ADDR_ENABLED, 32'h8);
        ahb_xfer(1'b1, SSIL_ADDR_ENABLE, 32'h0);
        idle(1);
        check({31'h0, irq_out}, 32'h0);
        $display("test levels done");
    endtask

    // Frame on a full FIFO, then clearing with zero and one
    task automatic test_overrun();
        tx_count_in <= 4'h5;
        rx_count_in <= 4'h7;
        frame_done_in <= 1'b1;
        @(negedge clock_in);
        check({31'h0, overwrite_last_out}, 32'h0);
        @(posedge clock_in);
        rx_count_in <= 4'h8;
        @(negedge clock_in);
        check({31'h0, overwrite_last_out}, 32'h1);
        @(posedge clock_in);
        frame_done_in <= 1'b0;
        read_chk(SSIL_ADDR_RAW, 32'h5);
        ahb_xfer(1'b1, SSIL_ADDR_ENABLE, 32'h1);
        read_chk(SSIL_ADDR_ENABLED, 32'h1);
        check({31'h0, irq_out}, 32'h1);
        ahb_xfer(1'b1, SSIL_ADDR_CLEAR, 32'h0);
        read_chk(SSIL_ADDR_RAW, 32'h5);
        ahb_xfer(1'b1, SSIL_ADDR_CLEAR, 32'h1);
        read_chk(SSIL_ADDR_RAW, 32'h4);
        read_chk(SSIL_ADDR_CLEAR, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        rx_count_in <= 4'h0;
        $display("test overrun done");
    endtask

    // Time-out after 32 bit times of 2 clocks, cleared two ways
    task automatic test_timeout();
        idle(2);
        rx_count_in <= 4'h1;
        // 32 bits of 2 clocks: the set shows from the 64th edge
        idle(int'(SSIL_TIMEOUT_BITS) * 2 - 1);
        read_chk(SSIL_ADDR_RAW, 32'h0);
        read_chk(SSIL_ADDR_RAW, 32'h2);
        ahb_xfer(1'b1, SSIL_ADDR_ENABLE, 32'h2);
        idle(1);
        check({31'h0, irq_out}, 32'h1);
        ahb_xfer(1'b1, SSIL_ADDR_CLEAR, 32'h2);
        read_chk(SSIL_ADDR_RAW, 32'h0);
        rx_count_in <= 4'h0;
        idle(2);
        rx_count_in <= 4'h1;
        idle(70);
        read_chk(SSIL_ADDR_ENABLED, 32'h2);
        rx_read_in <= 1'b1;
        @(posedge clock_in);
        rx_read_in <= 1'b0;
        read_chk(SSIL_ADDR_RAW, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        $display("test timeout done");
    endtask

    // Slower bit rate: 32 bits of 4 x 2 clocks
    task automatic test_rate();
        prescale_divisor_in <= 8'h04;
        clock_rate_factor_in <= 8'h01;
        rx_count_in <= 4'h0;
        idle(2);
        rx_count_in <= 4'h1;
        idle(int'(SSIL_TIMEOUT_BITS) * 8 - 1);
        read_chk(SSIL_ADDR_RAW, 32'h0);
        read_chk(SSIL_ADDR_RAW, 32'h2);
        check({31'h0, irq_out}, 32'h1);
        rx_count_in <= 4'h0;
        idle(1);
        read_chk(SSIL_ADDR_RAW, 32'h0);
        $display("test rate done");
    endtask

    // Reset in mid-run clears the enables and the sticky overrun
    task automatic test_mid_reset();
        ahb_xfer(1'b1, SSIL_ADDR_ENABLE, 32'hF);
        rx_count_in <= 4'h8;
        frame_done_in <= 1'b1;
        @(posedge clock_in);
        frame_done_in <= 1'b0;
        read_chk(SSIL_ADDR_RAW, 32'h5);
        check({31'h0, irq_out}, 32'h1);
        rst_n_in <= 1'b0;
        idle(2);
        check({31'h0, irq_out}, 32'h0);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        read_chk(SSIL_ADDR_ENABLE, 32'h0);
        read_chk(SSIL_ADDR_RAW, 32'h4);
        rx_count_in <= 4'h0;
        $display("test mid reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang limit
    always @(posedge clock_in) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        tx_count_in <= 4'h0;
        idle(20);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        test_reset();
        test_levels();
        test_overrun();
        test_timeout();
        test_rate();
        test_mid_reset();
        stop_test();
    end

endmodule
